/* File: include/hls_consts.vh */
// constants shared by the health log sector builder
`ifndef HLS_CONSTS_VH
`define HLS_CONSTS_VH
// timing
`define HLS_CLK_PERIOD_NS 5
`define HLS_MS_NS 1000000
// sector layout
`define HLS_SEC_LAST 9'h1ff
`define HLS_THR_REV_LO 8'h01
`define HLS_THR_FIRST 9'h002
`define HLS_THR_LAST 9'h169
`define HLS_ENT_SIZE 9'h00c
`define HLS_ENT_COUNT 5'h1e
`define HLS_THR_DEF 8'h0a
// threshold codes
`define HLS_THR_PASS 8'h00
`define HLS_THR_INVALID 8'hfe
`define HLS_THR_FAIL 8'hff
// log directory
`define HLS_LOG_VER 8'h01
`define HLS_DIR_ADDR 8'h00
`define HLS_ERRLOG_ADDR 8'h01
`define HLS_ERRLOG_SECS 8'h01
`define HLS_VEND_LO 8'h80
`define HLS_VEND_HI 8'h9f
`define HLS_VEND_SECS 8'h10
`define HLS_VEND_SEC_LAST 4'hf
// error log sector
`define HLS_ERR_VER 8'h01
`define HLS_REC_FIRST 9'h002
`define HLS_REC_END 9'h1c3
`define HLS_REC5_BASE 9'h16a
`define HLS_REC_BYTES 9'h05a
`define HLS_REC_LAST_OFS 7'h59
`define HLS_EDATA_OFS 7'h3c
`define HLS_ERR_REG_OFS 7'h3d
`define HLS_ERR_STAT_OFS 7'h43
`define HLS_CNT_LO 9'h1c4
`define HLS_CNT_HI 9'h1c5
`define HLS_CNT_MAX 16'hffff
`define HLS_PTR_MIN 3'h1
`define HLS_PTR_MAX 3'h5
`define HLS_SNAP_LAST 3'h4
`define HLS_SNAP_BYTE_LAST 4'hb
`endif

/* File: core/hls_mem.v */
// byte memory with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module hls_mem #(
   parameter AW = 9
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [7:0] wr_data,
   // read ports
   input wire [AW-1:0] rd_a_addr,
   output reg [7:0] rd_a_data,
   input wire [AW-1:0] rd_b_addr,
   output reg [7:0] rd_b_data
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_a_data <= 8'h00;
         rd_b_data <= 8'h00;
      end else begin
         rd_a_data <= mem[rd_a_addr];
         rd_b_data <= mem[rd_b_addr];
      end
   end
endmodule // hls_mem
`default_nettype wire

/* File: core/hls_thr_cmp.v */
// threshold comparison with the test codes and invalid code
`timescale 1ns/1ps
`default_nettype none
`include "hls_consts.vh"
module hls_thr_cmp (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // operands
   input wire in_valid,
   input wire [7:0] thr,
   input wire [7:0] value,
   // result
   output reg out_valid,
   output reg out_fail,
   output reg out_invalid
);
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_fail <= 1'b0;
         out_invalid <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_invalid <= (thr == `HLS_THR_INVALID);
            if (thr == `HLS_THR_PASS) begin
               out_fail <= 1'b0;
            end else if (thr == `HLS_THR_FAIL) begin
               out_fail <= 1'b1;
            end else if (thr == `HLS_THR_INVALID) begin
               out_fail <= 1'b0;
            end else begin
               out_fail <= (value <= thr);
            end
         end
      end
   end
endmodule // hls_thr_cmp
`default_nettype wire

/* File: core/hls_top.v */
// health log sector builder: threshold, directory and error log sectors
//
// What this block does
// - threshold entry is 12 bytes: id, threshold, then ten zero bytes
// - threshold entries keep the order of the attribute value entries
// - normal thresholds are 01h..FDh; FEh is flagged invalid
// - threshold 00h always passes, FFh always fails
// - factory thresholds at start; host writes after init replace them and read back
// - last sector byte makes all 512 bytes sum to zero
// - log address zero returns the one-sector log directory
// - directory starts with logging version word 01h
// - directory byte 2k gives sector count of log k; odd bytes reserved
// - logs 80h..9Fh are reported and returned as sixteen sectors
// - error sector: version, pointer, five 90-byte records, count, reserved
// - error log version byte is always 01h
// - pointer names newest record and stays within 1..5
// - error count increments per error, merging those that arrive while one is pending, and saturates
// - record is five 12-byte command snapshots then 30-byte error data
// - snapshot holds the taskfile bytes at command write, then command
// - snapshot bytes 8..11 hold wrapping millisecond timestamp
// - multi-byte fields are little-endian
// - threshold sector: revision, thirty entries, checksum at byte 511
`timescale 1ns/1ps
`default_nettype none
`include "hls_consts.vh"
module hls_top #(
   parameter MS_CYC = `HLS_MS_NS / `HLS_CLK_PERIOD_NS
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // command register capture
   input wire cmd_wr,
   input wire [7:0] cmd_dev_ctl,
   input wire [7:0] cmd_feat,
   input wire [7:0] cmd_scnt,
   input wire [7:0] cmd_lba_lo,
   input wire [7:0] cmd_lba_mid,
   input wire [7:0] cmd_lba_hi,
   input wire [7:0] cmd_dev_head,
   input wire [7:0] cmd_code,
   // error event
   input wire err_log,
   input wire [7:0] err_reg,
   input wire [7:0] err_stat,
   // threshold sector write
   input wire thr_wr,
   input wire [8:0] thr_wr_addr,
   input wire [7:0] thr_wr_data,
   // sector read
   input wire rd_req,
   input wire rd_thr,
   input wire [7:0] rd_log_addr,
   output wire rd_busy,
   output reg rd_valid,
   output reg [7:0] rd_data,
   output reg rd_sec_last,
   output reg rd_done,
   output reg rd_bad,
   // threshold compare
   input wire cmp_req,
   input wire [4:0] cmp_idx,
   input wire [7:0] cmp_value,
   output wire cmp_valid,
   output wire cmp_fail,
   output wire cmp_invalid,
   // status
   output wire init_busy,
   output reg [2:0] err_ptr_q,
   output reg [15:0] err_cnt_q,
   output reg [31:0] ms_q
);
   localparam [1:0] ST_INIT = 2'b00;
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_READ = 2'b10;
   localparam [1:0] ST_LOG = 2'b11;
   localparam [1:0] M_THR = 2'b00;
   localparam [1:0] M_DIR = 2'b01;
   localparam [1:0] M_ERR = 2'b10;
   localparam [1:0] M_VEND = 2'b11;
   localparam integer MS_LAST_I = MS_CYC - 1;

   // ----------
   // decoding functions
   // ----------
   // threshold sector byte to {stored, entry, id/threshold}
   function [6:0] hls_thr_map;
      input [8:0] a;
      reg [8:0] r;
      reg [8:0] e;
      reg [8:0] b;
      begin
         r = a - `HLS_THR_FIRST;
         e = r / `HLS_ENT_SIZE;
         b = r - e * `HLS_ENT_SIZE;
         hls_thr_map = {(a >= `HLS_THR_FIRST) && (a <= `HLS_THR_LAST) &&
                        (b < 9'h002), e[4:0], b[0]};
      end
   endfunction

   // sector count reported for a log address
   function [7:0] hls_dir_secs;
      input [7:0] k;
      begin
         if (k >= `HLS_VEND_LO && k <= `HLS_VEND_HI) begin
            hls_dir_secs = `HLS_VEND_SECS;
         end else if (k == `HLS_ERRLOG_ADDR) begin
            hls_dir_secs = `HLS_ERRLOG_SECS;
         end else begin
            hls_dir_secs = 8'h00;
         end
      end
   endfunction

   // factory threshold memory contents
   function [7:0] hls_thr_default;
      input [5:0] i;
      begin
         if (i[5:1] >= `HLS_ENT_COUNT) begin
            hls_thr_default = 8'h00;
         end else if (i[0] == 1'b0) begin
            hls_thr_default = {3'b000, i[5:1]} + 8'h01;
         end else begin
            hls_thr_default = `HLS_THR_DEF;
         end
      end
   endfunction

   // byte of a snapshot word, low byte first
   function [7:0] hls_snap_byte;
      input [95:0] w;
      input [3:0] b;
      begin
         hls_snap_byte = w[b*8 +: 8];
      end
   endfunction

   // ----------
   // millisecond timer
   // ----------
   reg [17:0] div_q;
   wire ms_tick = (div_q == MS_LAST_I[17:0]);

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= 18'h0_0000;
         ms_q <= 32'h0000_0000;
      end else begin
         div_q <= ms_tick ? 18'h0_0000 : div_q + 18'h0_0001;
         if (ms_tick) begin
            ms_q <= ms_q + 32'h0000_0001;
         end
      end
   end

   // ----------
   // command snapshots
   // ----------
   reg [95:0] snap_q [0:4];
   reg [95:0] frz_q [0:4];
   reg [1:0] state_q;
   reg err_pend_q;
   wire err_go = (state_q == ST_IDLE) && err_pend_q;

   genvar g;
   generate
      for (g = 0; g <= 4; g = g + 1) begin : g_snap
         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               snap_q[g] <= 96'h0;
               frz_q[g] <= 96'h0;
            end else begin
               if (cmd_wr) begin
                  if (g == 0) begin
                     snap_q[g] <= {ms_q, cmd_code, cmd_dev_head, cmd_lba_hi,
                                   cmd_lba_mid, cmd_lba_lo, cmd_scnt, cmd_feat,
                                   cmd_dev_ctl};
                  end else begin
                     snap_q[g] <= snap_q[g-1];
                  end
               end
               if (err_go) begin
                  frz_q[g] <= snap_q[g];
               end
            end
         end
      end
   endgenerate

   // ----------
   // control state
   // ----------
   reg [8:0] idx_q;
   reg [1:0] mode_q;
   reg [3:0] sec_q;
   reg v1_q;
   reg [8:0] idx1_q;
   reg last1_q;
   reg [7:0] sum_q;
   reg [8:0] base_q;
   reg [6:0] ofs_q;
   reg [2:0] sn_q;
   reg [3:0] bi_q;
   reg [7:0] err_reg_q;
   reg [7:0] err_stat_q;
   reg cmp_v1_q;
   reg [7:0] cmp_val1_q;
   wire rd_ok = (rd_log_addr == `HLS_DIR_ADDR) ||
                (hls_dir_secs(rd_log_addr) != 8'h00);
   wire rd_go = (state_q == ST_IDLE) && !v1_q && !err_pend_q && rd_req;
   wire [3:0] sec_end = (mode_q == M_VEND) ? `HLS_VEND_SEC_LAST : 4'h0;

   assign rd_busy = (state_q != ST_IDLE) || v1_q || err_pend_q;
   assign init_busy = (state_q == ST_INIT);

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_INIT;
         idx_q <= 9'h000;
         mode_q <= M_THR;
         sec_q <= 4'h0;
         err_pend_q <= 1'b0;
         err_ptr_q <= `HLS_PTR_MAX;
         err_cnt_q <= 16'h0000;
         base_q <= `HLS_REC5_BASE;
         ofs_q <= 7'h00;
         sn_q <= 3'h0;
         bi_q <= 4'h0;
         err_reg_q <= 8'h00;
         err_stat_q <= 8'h00;
         rd_bad <= 1'b0;
      end else begin
         rd_bad <= (state_q == ST_IDLE) && !v1_q && !err_pend_q && rd_req &&
                   !rd_thr && !rd_ok;
         if (err_log) begin
            err_pend_q <= 1'b1;
            err_reg_q <= err_reg;
            err_stat_q <= err_stat;
         end else if (err_go) begin
            err_pend_q <= 1'b0;
         end
         case (state_q)
            ST_INIT: begin
               idx_q <= idx_q + 9'h001;
               if (idx_q == `HLS_SEC_LAST) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (err_go) begin
                  state_q <= ST_LOG;
                  ofs_q <= 7'h00;
                  sn_q <= 3'h0;
                  bi_q <= 4'h0;
                  if (err_ptr_q == `HLS_PTR_MAX) begin
                     err_ptr_q <= `HLS_PTR_MIN;
                     base_q <= `HLS_REC_FIRST;
                  end else begin
                     err_ptr_q <= err_ptr_q + 3'h1;
                     base_q <= base_q + `HLS_REC_BYTES;
                  end
                  if (err_cnt_q != `HLS_CNT_MAX) begin
                     err_cnt_q <= err_cnt_q + 16'h0001;
                  end
               end else if (rd_go && (rd_thr || rd_ok)) begin
                  state_q <= ST_READ;
                  idx_q <= 9'h000;
                  sec_q <= 4'h0;
                  if (rd_thr) begin
                     mode_q <= M_THR;
                  end else if (rd_log_addr == `HLS_DIR_ADDR) begin
                     mode_q <= M_DIR;
                  end else if (rd_log_addr == `HLS_ERRLOG_ADDR) begin
                     mode_q <= M_ERR;
                  end else begin
                     mode_q <= M_VEND;
                  end
               end
            end
            ST_READ: begin
               idx_q <= idx_q + 9'h001;
               if (idx_q == `HLS_SEC_LAST) begin
                  sec_q <= sec_q + 4'h1;
                  if (sec_q == sec_end) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_LOG: begin
               ofs_q <= ofs_q + 7'h01;
               if (bi_q == `HLS_SNAP_BYTE_LAST) begin
                  bi_q <= 4'h0;
                  sn_q <= sn_q + 3'h1;
               end else begin
                  bi_q <= bi_q + 4'h1;
               end
               if (ofs_q == `HLS_REC_LAST_OFS) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------
   // memories
   // ----------
   wire [6:0] map0 = hls_thr_map(idx_q);
   wire [6:0] map1 = hls_thr_map(idx1_q);
   wire [6:0] map_wr = hls_thr_map(thr_wr_addr);
   reg [7:0] log_wdata;
   wire [7:0] thr_rd_a;
   wire [7:0] thr_rd_b;
   wire [7:0] err_rd_a;
   wire thr_we = init_busy || (thr_wr && map_wr[6]);
   wire [5:0] thr_waddr = init_busy ? idx_q[5:0] : map_wr[5:0];
   wire [7:0] thr_wdata = init_busy ? hls_thr_default(idx_q[5:0]) : thr_wr_data;
   wire err_we = init_busy || (state_q == ST_LOG);
   wire [8:0] err_waddr = init_busy ? idx_q : base_q + {2'b00, ofs_q};
   wire [7:0] err_wdata = init_busy ? 8'h00 : log_wdata;

   // record byte: oldest snapshot first, newest last, then error data
   always @* begin
      if (ofs_q < `HLS_EDATA_OFS) begin
         log_wdata = hls_snap_byte(frz_q[`HLS_SNAP_LAST - sn_q], bi_q);
      end else if (ofs_q == `HLS_ERR_REG_OFS) begin
         log_wdata = err_reg_q;
      end else if (ofs_q == `HLS_ERR_STAT_OFS) begin
         log_wdata = err_stat_q;
      end else begin
         log_wdata = 8'h00;
      end
   end

   hls_mem #(.AW(6)) u_thr_mem (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(thr_we),
      .wr_addr(thr_waddr),
      .wr_data(thr_wdata),
      .rd_a_addr(map0[5:0]),
      .rd_a_data(thr_rd_a),
      .rd_b_addr({cmp_idx, 1'b1}),
      .rd_b_data(thr_rd_b)
   );

   hls_mem #(.AW(9)) u_err_mem (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(err_we),
      .wr_addr(err_waddr),
      .wr_data(err_wdata),
      .rd_a_addr(idx_q),
      .rd_a_data(err_rd_a),
      .rd_b_addr(9'h000),
      .rd_b_data()
   );

   // ----------
   // sector output stage
   // ----------
   reg [7:0] byte1;

   always @* begin
      byte1 = 8'h00;
      case (mode_q)
         M_THR: begin
            if (idx1_q == 9'h000) begin
               byte1 = `HLS_THR_REV_LO;
            end else if (map1[6]) begin
               byte1 = thr_rd_a;
            end
         end
         M_DIR: begin
            if (idx1_q == 9'h000) begin
               byte1 = `HLS_LOG_VER;
            end else if (idx1_q[0] == 1'b0) begin
               byte1 = hls_dir_secs(idx1_q[8:1]);
            end
         end
         M_ERR: begin
            if (idx1_q == 9'h000) begin
               byte1 = `HLS_ERR_VER;
            end else if (idx1_q == 9'h001) begin
               byte1 = {5'b00000, err_ptr_q};
            end else if (idx1_q <= `HLS_REC_END) begin
               byte1 = err_rd_a;
            end else if (idx1_q == `HLS_CNT_LO) begin
               byte1 = err_cnt_q[7:0];
            end else if (idx1_q == `HLS_CNT_HI) begin
               byte1 = err_cnt_q[15:8];
            end
         end
         default: begin
            byte1 = 8'h00;
         end
      endcase
      if (idx1_q == `HLS_SEC_LAST) begin
         byte1 = 8'h00 - sum_q;
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         v1_q <= 1'b0;
         idx1_q <= 9'h000;
         last1_q <= 1'b0;
         sum_q <= 8'h00;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         rd_sec_last <= 1'b0;
         rd_done <= 1'b0;
         cmp_v1_q <= 1'b0;
         cmp_val1_q <= 8'h00;
      end else begin
         v1_q <= (state_q == ST_READ);
         idx1_q <= idx_q;
         last1_q <= (sec_q == sec_end);
         cmp_v1_q <= cmp_req;
         cmp_val1_q <= cmp_value;
         rd_valid <= v1_q;
         rd_data <= v1_q ? byte1 : 8'h00;
         rd_sec_last <= v1_q && (idx1_q == `HLS_SEC_LAST);
         rd_done <= v1_q && (idx1_q == `HLS_SEC_LAST) && last1_q;
         if (v1_q) begin
            sum_q <= (idx1_q == 9'h000) ? byte1 : sum_q + byte1;
         end
      end
   end

   // ----------
   // threshold compare
   // ----------
   hls_thr_cmp u_cmp (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(cmp_v1_q),
      .thr(thr_rd_b),
      .value(cmp_val1_q),
      .out_valid(cmp_valid),
      .out_fail(cmp_fail),
      .out_invalid(cmp_invalid)
   );
endmodule // hls_top
`default_nettype wire

/* File: testbench/hls_top_props.sv */
// assertions on the health log sector builder ports
`timescale 1ns/1ps
`default_nettype none
module hls_top_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // read and compare
   input wire logic rd_req,
   input wire logic rd_thr,
   input wire logic rd_busy,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   input wire logic rd_sec_last,
   input wire logic cmp_req,
   input wire logic cmp_valid,
   // status
   input wire logic [2:0] err_ptr_q,
   input wire logic [15:0] err_cnt_q,
   input wire logic [31:0] ms_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------
   // byte index and running sum of a sector
   // ----------
   logic [8:0] idx_q;
   logic [7:0] sum_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         idx_q <= 9'h000;
         sum_q <= 8'h00;
      end else if (rd_valid) begin
         idx_q <= idx_q + 9'h001;
         sum_q <= rd_sec_last ? 8'h00 : sum_q + rd_data;
      end
   end
   // ----------
   // properties
   // ----------
   property p_ptr_range;
      err_ptr_q >= 3'h1 && err_ptr_q <= 3'h5;
   endproperty
   a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
   property p_ptr_wrap;
      err_ptr_q != $past(err_ptr_q) |->
         err_ptr_q == (($past(err_ptr_q) == 3'h5) ? 3'h1 : $past(err_ptr_q) + 3'h1);
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer step wrong");
   property p_cnt_step;
      err_cnt_q != $past(err_cnt_q) |-> err_cnt_q == $past(err_cnt_q) + 16'h0001;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("error count step wrong");
   property p_cnt_sat;
      err_cnt_q == 16'hffff |=> err_cnt_q == 16'hffff;
   endproperty
   a_cnt_sat: assert property (p_cnt_sat) else $error("error count wrapped");
   property p_ptr_cnt;
      $changed(err_ptr_q) |-> $changed(err_cnt_q) || err_cnt_q == 16'hffff;
   endproperty
   a_ptr_cnt: assert property (p_ptr_cnt) else $error("pointer moved without count");
   property p_sec_len;
      rd_sec_last |-> rd_valid && idx_q == 9'h1ff;
   endproperty
   a_sec_len: assert property (p_sec_len) else $error("sector not 512 bytes");
   property p_sec_sum;
      rd_sec_last |-> (sum_q + rd_data) == 8'h00;
   endproperty
   a_sec_sum: assert property (p_sec_sum) else $error("sector sum not zero");
   property p_rd_start;
      rd_req && rd_thr && !rd_busy |-> ##[3:4] rd_valid;
   endproperty
   a_rd_start: assert property (p_rd_start) else $error("threshold read did not start");
   property p_cmp_lat;
      cmp_req |-> ##[2:3] cmp_valid;
   endproperty
   a_cmp_lat: assert property (p_cmp_lat) else $error("compare result missing");
   property p_ms_step;
      ms_q != $past(ms_q) |-> ms_q == $past(ms_q) + 32'h0000_0001;
   endproperty
   a_ms_step: assert property (p_ms_step) else $error("millisecond step wrong");
endmodule // hls_top_props
`default_nettype wire

/* File: testbench/hls_host_mdl.sv */
// host model that captures streamed sectors and checks their sums
`timescale 1ns/1ps
`default_nettype none
module hls_host_mdl (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clr,
   // read stream
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   input wire logic rd_sec_last,
   // capture results
   output logic [13:0] n_bytes_q,
   output logic [4:0] n_secs_q,
   output logic sum_bad_q
);
   logic [7:0] buf_q [0:8191];
   logic [7:0] sum_q;
   always @(posedge core_clk) begin
      if (rst || clr) begin
         n_bytes_q <= 14'h0000;
         n_secs_q <= 5'h00;
         sum_q <= 8'h00;
         if (rst) sum_bad_q <= 1'b0;
      end else if (rd_valid) begin
         buf_q[n_bytes_q[12:0]] <= rd_data;
         n_bytes_q <= n_bytes_q + 14'h0001;
         sum_q <= rd_sec_last ? 8'h00 : sum_q + rd_data;
         if (rd_sec_last) n_secs_q <= n_secs_q + 5'h01;
         if (rd_sec_last && (sum_q + rd_data) != 8'h00) sum_bad_q <= 1'b1;
      end
   end
endmodule // hls_host_mdl
`default_nettype wire

/* File: testbench/tb.sv */
// testbench for the health log sector builder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb;
   localparam int MS_CYC = 10;
   logic core_clk, rst, cmd_wr, err_log, thr_wr, rd_req, rd_thr, cmp_req, clr, bad_seen;
   logic [7:0] cb [0:7];
   logic [7:0] err_reg, err_stat, thr_wr_data, rd_log_addr, cmp_value;
   logic [8:0] thr_wr_addr;
   logic [4:0] cmp_idx;
   wire logic rd_busy, rd_valid, rd_sec_last, rd_done, rd_bad, cmp_valid, cmp_fail;
   wire logic cmp_invalid, init_busy, sum_bad_q;
   wire logic [7:0] rd_data;
   wire logic [2:0] err_ptr_q;
   wire logic [15:0] err_cnt_q;
   wire logic [31:0] ms_q;
   wire logic [13:0] n_bytes_q;
   wire logic [4:0] n_secs_q;
   int miscompares = 0, check_count = 0, cyc = 0, ts_exp = 0;
   hls_top #(.MS_CYC(MS_CYC)) DUT (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr),
      .cmd_dev_ctl(cb[0]), .cmd_feat(cb[1]), .cmd_scnt(cb[2]), .cmd_lba_lo(cb[3]),
      .cmd_lba_mid(cb[4]), .cmd_lba_hi(cb[5]), .cmd_dev_head(cb[6]), .cmd_code(cb[7]),
      .err_log(err_log), .err_reg(err_reg), .err_stat(err_stat), .thr_wr(thr_wr),
      .thr_wr_addr(thr_wr_addr), .thr_wr_data(thr_wr_data), .rd_req(rd_req), .rd_thr(rd_thr),
      .rd_log_addr(rd_log_addr), .rd_busy(rd_busy), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_sec_last(rd_sec_last), .rd_done(rd_done), .rd_bad(rd_bad), .cmp_req(cmp_req),
      .cmp_idx(cmp_idx), .cmp_value(cmp_value), .cmp_valid(cmp_valid), .cmp_fail(cmp_fail),
      .cmp_invalid(cmp_invalid), .init_busy(init_busy), .err_ptr_q(err_ptr_q),
      .err_cnt_q(err_cnt_q), .ms_q(ms_q));
   hls_host_mdl host (.core_clk(core_clk), .rst(rst), .clr(clr), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_sec_last(rd_sec_last), .n_bytes_q(n_bytes_q),
      .n_secs_q(n_secs_q), .sum_bad_q(sum_bad_q));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
   // ----------
   // bus tasks
   // ----------
   task automatic wait_idle();
      for (int n = 0; n < 20000 && rd_busy !== 1'b0; n++) @(negedge core_clk);
   endtask
   task automatic rd_sec(input logic thr, input logic [7:0] addr);
      wait_idle();
      clr = 1'b1;
      @(negedge core_clk);
      clr = 1'b0;
      bad_seen = 1'b0;
      rd_req = 1'b1;
      rd_thr = thr;
      rd_log_addr = addr;
      @(negedge core_clk);
      rd_req = 1'b0;
      for (int n = 0; n < 9000 && rd_done !== 1'b1 && rd_bad !== 1'b1; n++) @(negedge core_clk);
      `CHK(rd_done | rd_bad, 1'b1)
      bad_seen = (rd_bad === 1'b1);
      @(negedge core_clk);
   endtask
   task automatic cmp(input logic [4:0] idx, input logic [7:0] v, input logic ef, input logic ei);
      cmp_req = 1'b1;
      cmp_idx = idx;
      cmp_value = v;
      @(negedge core_clk);
      cmp_req = 1'b0;
      for (int n = 0; n < 4 && cmp_valid !== 1'b1; n++) @(negedge core_clk);
      `CHK({cmp_valid, cmp_fail, cmp_invalid}, {1'b1, ef, ei})
   endtask
   task automatic do_cmd(input logic [7:0] b);
      for (int i = 0; i < 8; i++) cb[i] = b + 8'(i);
      cmd_wr = 1'b1;
      @(negedge core_clk);
      cmd_wr = 1'b0;
      ts_exp = cyc / MS_CYC;
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_thr();
      logic [7:0] nz;
      logic [7:0] tv [0:3];
      tv = '{8'h00, 8'hff, 8'hfe, 8'h80};
      rd_sec(1'b1, 8'h00);
      `CHK(host.buf_q[0], 8'h01)
      for (int e = 0; e < 30; e++) begin
         nz = 8'h00;
         for (int z = 2; z < 12; z++) nz = nz | host.buf_q[2 + 12 * e + z];
         `CHK(host.buf_q[2 + 12 * e], 8'(e + 1))
         `CHK({host.buf_q[3 + 12 * e], nz}, 16'h0a00)
      end
      `CHK({n_secs_q, sum_bad_q}, 6'h02)
      thr_wr = 1'b1;
      for (int e = 0; e < 5; e++) begin
         thr_wr_addr = (e == 4) ? 9'h004 : 9'(3 + 12 * e);
         thr_wr_data = (e == 4) ? 8'h55 : tv[e];
         @(negedge core_clk);
      end
      thr_wr = 1'b0;
      rd_sec(1'b1, 8'h00);
      for (int e = 0; e < 4; e++) `CHK(host.buf_q[3 + 12 * e], tv[e])
      `CHK({host.buf_q[4], sum_bad_q}, 9'h000)
      cmp(5'd0, 8'hff, 1'b0, 1'b0);
      cmp(5'd1, 8'h00, 1'b1, 1'b0);
      cmp(5'd2, 8'h10, 1'b0, 1'b1);
      cmp(5'd3, 8'h80, 1'b1, 1'b0);
      cmp(5'd3, 8'h81, 1'b0, 1'b0);
      cmp(5'd5, 8'h0a, 1'b1, 1'b0);
      $display("threshold sector test done");
   endtask
   task automatic t_dir();
      rd_sec(1'b0, 8'h00);
      `CHK({host.buf_q[1], host.buf_q[0]}, 16'h0001)
      `CHK({host.buf_q[2], host.buf_q[3], host.buf_q[320]}, 24'h01_0000)
      `CHK({host.buf_q[256], host.buf_q[318]}, 16'h1010)
      `CHK({n_bytes_q, sum_bad_q}, 15'h0400)
      rd_sec(1'b0, 8'h9f);
      `CHK({n_secs_q, n_bytes_q}, 19'h4_2000)
      rd_sec(1'b0, 8'h02);
      `CHK({bad_seen, n_bytes_q}, 15'h4000)
      $display("directory test done");
   endtask
   task automatic t_err();
      logic [31:0] ts;
      `CHK({init_busy, err_ptr_q, err_cnt_q}, 20'hd_0000)
      for (int j = 1; j <= 6; j++) begin
         do_cmd(8'(16 * j - 8));
         do_cmd(8'(16 * j));
         err_reg = 8'(16 * j + 1);
         err_stat = 8'(16 * j + 2);
         err_log = 1'b1;
         @(negedge core_clk);
         err_log = 1'b0;
         wait_idle();
         `CHK(err_ptr_q, 3'((j - 1) % 5 + 1))
         `CHK(err_cnt_q, 16'(j))
      end
      rd_sec(1'b0, 8'h01);
      `CHK({host.buf_q[0], host.buf_q[1]}, 16'h0101)
      `CHK({host.buf_q[453], host.buf_q[452], host.buf_q[454]}, 24'h00_0600)
      for (int i = 0; i < 8; i++) begin
         `CHK(host.buf_q[50 + i], 8'(96 + i))
         `CHK(host.buf_q[38 + i], 8'(88 + i))
         `CHK(host.buf_q[140 + i], 8'(32 + i))
      end
      `CHK({host.buf_q[63], host.buf_q[69], host.buf_q[62]}, 24'h61_6200)
      ts = {host.buf_q[61], host.buf_q[60], host.buf_q[59], host.buf_q[58]};
      `CHK(int'(ts) >= ts_exp - 1 && int'(ts) <= ts_exp + 1, 1'b1)
      `CHK(sum_bad_q, 1'b0)
      $display("error log test done");
   endtask
   // ----------
   // run control
   // ----------
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end
   initial begin
      {rst, cmd_wr, err_log, thr_wr, rd_req, rd_thr, cmp_req, clr, bad_seen} = 9'h100;
      for (int i = 0; i < 8; i++) cb[i] = 8'h00;
      {err_reg, err_stat, thr_wr_data, rd_log_addr, cmp_value} = 40'h0;
      thr_wr_addr = 9'h000;
      cmp_idx = 5'h00;
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      t_err();
      t_thr();
      t_dir();
      end_of_test();
   end
endmodule // tb
bind hls_top hls_top_props u_props (.core_clk(core_clk), .rst(rst),
   .rd_req(rd_req), .rd_thr(rd_thr), .rd_busy(rd_busy), .rd_valid(rd_valid),
   .rd_data(rd_data), .rd_sec_last(rd_sec_last), .cmp_req(cmp_req), .cmp_valid(cmp_valid),
   .err_ptr_q(err_ptr_q), .err_cnt_q(err_cnt_q), .ms_q(ms_q));
`default_nettype wire
